// >>> spg_sleep_clock_ctrl.v
/*
 * Sleep mode sequencer and clock gating for an 8-bit controller: domain
 * clock enables, oscillator enables, wake-up source arming, per-module
 * clock shutdown and the analog enables that follow the sleep state.
 * Assumes one 10 MHz clock, an AXI4-Lite master on the same clock, and
 * that the sleep request and the internal wake events come from logic on
 * that clock. External interrupt and pin change inputs are raw pins.
 */
// Added by the designer: the register offsets and the AXI4-Lite register port.
// Contract
// - Sleep with mode 110 enters Standby.
// - Standby equals Power-down but keeps the main oscillator running.
// - Standby wake-up resumes execution after six clock cycles.
// - Idle and noise reduction keep timer oscillator only if timer B async.
// - Deep modes wake on external lines only when level sensed.
// - Power-down and Standby wake only from ext, pin, two-wire, watchdog.
// - A shutdown bit stops the module clock and blocks its registers.
// - Clearing the bit restarts the clock from the frozen state.
// - Module shutdown only matters in Active and Idle; the converter bit also stops the converter clock in noise reduction.
// - Shutdown register bit map; bit 4 reads zero; reset all zero.
// - Timer B shutdown acts only while timer B runs synchronously.
// - Converter disabled first; while stopped, comparator loses the mux.
// - Converter stays enabled in sleep; re-enable forces extended conversion.
// - Comparator is disabled in sleep modes beyond noise reduction.
// - A fused brown-out detector stays active in all sleep modes.
// - Reference is on exactly when brown-out, comparator or converter need it.
// - An enabled watchdog keeps running in every sleep mode.
// - Input buffers off when I/O and converter clocks both stop.
// - Input disable registers turn off selected analog pin buffers.
// - Debug fuse keeps the main clock source on in every sleep mode.
// - Mode codes: 000 idle, 001 noise reduction, 010 down, 011 save.
// - Idle halts only the CPU and program memory clocks.
// - Noise reduction also halts I/O, keeps converter and async clocks.
// - Power-down halts every generated clock and the oscillator.
`include "spg_sleep_regs.vh"
`default_nettype none

module spg_sleep_clock_ctrl #(
  parameter ADDR_W = 8,
  parameter [15:0] OSC_START_CYC = 16'h0010
) (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [ADDR_W-1:0] s_axi_awaddr_i,
  input wire s_axi_awvalid_i,
  output reg s_axi_awready_o,
  input wire [31:0] s_axi_wdata_i,
  input wire [3:0] s_axi_wstrb_i,
  input wire s_axi_wvalid_i,
  output reg s_axi_wready_o,
  output reg [1:0] s_axi_bresp_o,
  output reg s_axi_bvalid_o,
  input wire s_axi_bready_i,
  input wire [ADDR_W-1:0] s_axi_araddr_i,
  input wire s_axi_arvalid_i,
  output reg s_axi_arready_o,
  output reg [31:0] s_axi_rdata_o,
  output reg [1:0] s_axi_rresp_o,
  output reg s_axi_rvalid_o,
  input wire s_axi_rready_i,
  input wire sleep_req_i,
  input wire ext_irq_line_a_i,
  input wire ext_irq_line_b_i,
  input wire pin_change_i,
  input wire two_wire_match_i,
  input wire timer_b_irq_i,
  input wire nvm_ready_irq_i,
  input wire converter_done_irq_i,
  input wire watchdog_irq_i,
  input wire other_io_irq_i,
  input wire timer_b_async_select_i,
  input wire converter_enable_i,
  input wire converter_start_i,
  input wire comparator_enable_i,
  input wire brownout_level_fuse_i,
  input wire debug_wire_fuse_i,
  input wire watchdog_enable_i,
  output reg cpu_clk_en_o,
  output reg flash_clk_en_o,
  output reg io_clk_en_o,
  output reg converter_clk_en_o,
  output reg async_timer_clock_en_o,
  output reg main_osc_en_o,
  output reg timer_osc_en_o,
  output reg [7:0] periph_clk_en_o,
  output reg [7:0] periph_access_en_o,
  output reg comparator_en_o,
  output reg comparator_mux_allow_o,
  output reg converter_en_o,
  output reg converter_extended_o,
  output reg brownout_en_o,
  output reg vref_en_o,
  output reg watchdog_run_o,
  output reg input_buf_en_o,
  output reg [15:0] analog_input_disable_o,
  output reg sleeping_o
);

  localparam [1:0] ST_ACTIVE = 2'h0;
  localparam [1:0] ST_SLEEP = 2'h1;
  localparam [1:0] ST_WAKE = 2'h2;

  // ----------------------------------------------------------------------
  // Address decoding shared by the read and write paths
  // ----------------------------------------------------------------------
  function [2:0] reg_index;
    input [ADDR_W-1:0] addr;
    begin
      case (addr[7:0])
        `SPG_ADDR_PCS: reg_index = `SPG_IDX_PCS;
        `SPG_ADDR_SLEEP_CTRL: reg_index = `SPG_IDX_SLEEP_CTRL;
        `SPG_ADDR_IN_DIS_LO: reg_index = `SPG_IDX_IN_DIS_LO;
        `SPG_ADDR_IN_DIS_HI: reg_index = `SPG_IDX_IN_DIS_HI;
        `SPG_ADDR_IRQ_SENSE: reg_index = `SPG_IDX_IRQ_SENSE;
        `SPG_ADDR_STATUS: reg_index = `SPG_IDX_STATUS;
        default: reg_index = `SPG_IDX_NONE;
      endcase
    end
  endfunction

  reg [7:0] pcs_q;
  reg [3:0] slp_ctrl_q;
  reg [7:0] in_dis_lo_q;
  reg [7:0] in_dis_hi_q;
  reg [1:0] sense_q;
  reg [1:0] state_q;
  reg [2:0] mode_q;
  reg [15:0] wake_cnt_q;
  reg conv_en_prev_q;
  reg conv_ext_q;
  reg [ADDR_W-1:0] awaddr_q;
  reg aw_got_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg w_got_q;

  // ----------------------------------------------------------------------
  // Pin synchronisers: the first stage is read by the second only, and a
  // new level is taken once the second and third stages agree.
  // ----------------------------------------------------------------------
  wire [2:0] pin_raw = {pin_change_i, ext_irq_line_b_i, ext_irq_line_a_i};
  reg [2:0] pin_s1_q;
  reg [2:0] pin_s2_q;
  reg [2:0] pin_s3_q;
  reg [2:0] pin_lvl_q;
  reg [2:0] pin_chg_q;
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin_sync
      always @(posedge sys_clk_i) begin
        // The chain fills during reset too, so the level held at release
        // is the pin's own and no false change follows reset.
        pin_s1_q[gi] <= pin_raw[gi];
        pin_s2_q[gi] <= pin_s1_q[gi];
        pin_s3_q[gi] <= pin_s2_q[gi];
        if (rst_i) begin
          pin_lvl_q[gi] <= pin_s3_q[gi];
          pin_chg_q[gi] <= 1'b0;
        end else begin
          if (pin_s2_q[gi] == pin_s3_q[gi]) begin
            pin_lvl_q[gi] <= pin_s3_q[gi];
            pin_chg_q[gi] <= pin_s3_q[gi] != pin_lvl_q[gi];
          end else begin
            pin_chg_q[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Wake-up source arming per sleep mode
  // ----------------------------------------------------------------------
  wire m_idle = mode_q == `SPG_MODE_IDLE;
  wire m_noise = mode_q == `SPG_MODE_NOISE_RED;
  wire m_save = mode_q == `SPG_MODE_POWER_SAVE;
  wire m_standby = mode_q == `SPG_MODE_STANDBY;
  wire lvl_a = sense_q[`SPG_SENSE_A_BIT] & ~pin_lvl_q[0];
  wire lvl_b = sense_q[`SPG_SENSE_B_BIT] & ~pin_lvl_q[1];
  wire edge_a = ~sense_q[`SPG_SENSE_A_BIT] & pin_chg_q[0];
  wire edge_b = ~sense_q[`SPG_SENSE_B_BIT] & pin_chg_q[1];
  wire wake_ext = lvl_a | lvl_b | (m_idle & (edge_a | edge_b));
  wire wake_any = wake_ext | pin_chg_q[2] | two_wire_match_i |
                  watchdog_irq_i |
                  ((m_idle | m_noise | m_save) & timer_b_irq_i) |
                  ((m_idle | m_noise) &
                   (nvm_ready_irq_i | converter_done_irq_i)) |
                  (m_idle & other_io_irq_i);

  wire mode_ok = (slp_ctrl_q[`SPG_SLP_MODE_MSB:`SPG_SLP_MODE_LSB] <=
                  `SPG_MODE_POWER_SAVE) |
                 (slp_ctrl_q[`SPG_SLP_MODE_MSB:`SPG_SLP_MODE_LSB] ==
                  `SPG_MODE_STANDBY);
  wire enter = sleep_req_i & slp_ctrl_q[`SPG_SLP_EN_BIT] & mode_ok;

  // ----------------------------------------------------------------------
  // Sleep sequencer
  // ----------------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      state_q <= ST_ACTIVE;
      mode_q <= `SPG_MODE_IDLE;
      wake_cnt_q <= 16'h0000;
    end else begin
      case (state_q)
        ST_ACTIVE: begin
          if (enter) begin
            // Standby is taken even without a crystal; the clock
            // source choice is left to software.
            mode_q <= slp_ctrl_q[`SPG_SLP_MODE_MSB:`SPG_SLP_MODE_LSB];
            state_q <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (wake_any) begin
            state_q <= ST_WAKE;
            if (m_standby) begin
              wake_cnt_q <= `SPG_STANDBY_WAKE_CYC;
            end else if (m_idle | m_noise) begin
              wake_cnt_q <= `SPG_QUICK_WAKE_CYC;
            end else begin
              wake_cnt_q <= OSC_START_CYC;
            end
          end
        end
        ST_WAKE: begin
          if (wake_cnt_q <= `SPG_QUICK_WAKE_CYC) begin
            state_q <= ST_ACTIVE;
          end
          wake_cnt_q <= wake_cnt_q - `SPG_QUICK_WAKE_CYC;
        end
        default: begin
          state_q <= ST_ACTIVE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Clock domain and oscillator plan for the present state
  // ----------------------------------------------------------------------
  reg run_cpu;
  reg run_io;
  reg run_conv;
  reg run_asy;
  reg run_main;
  reg run_tosc;
  always @* begin
    run_cpu = 1'b1;
    run_io = 1'b1;
    run_conv = 1'b1;
    run_asy = 1'b1;
    run_main = 1'b1;
    run_tosc = timer_b_async_select_i;
    if (state_q != ST_ACTIVE) begin
      run_cpu = 1'b0;
      case (mode_q)
        `SPG_MODE_IDLE: begin
          run_tosc = timer_b_async_select_i;
        end
        `SPG_MODE_NOISE_RED: begin
          run_io = 1'b0;
          run_tosc = timer_b_async_select_i;
        end
        `SPG_MODE_POWER_SAVE: begin
          run_io = 1'b0;
          run_conv = 1'b0;
          run_main = 1'b0;
          run_tosc = 1'b1;
        end
        `SPG_MODE_STANDBY: begin
          run_io = 1'b0;
          run_conv = 1'b0;
          run_asy = 1'b0;
          run_tosc = 1'b0;
        end
        default: begin
          run_io = 1'b0;
          run_conv = 1'b0;
          run_asy = 1'b0;
          run_main = 1'b0;
          run_tosc = 1'b0;
        end
      endcase
    end
    // Wake-up counts run while the CPU is still held, so the oscillator
    // must already be up: in Standby it never stopped.
    if (state_q == ST_WAKE || m_standby) begin
      run_main = run_main | (state_q == ST_WAKE) | m_standby;
    end
    run_main = run_main | debug_wire_fuse_i;
  end

  // Shutdown bits only reach modules whose domain still runs, so in the
  // deeper modes the domain gate alone decides.
  wire [7:0] pcs_eff = pcs_q & `SPG_PCS_WMASK;
  wire tb_sync_stop = pcs_eff[`SPG_PCS_TIMER_B] & ~timer_b_async_select_i;
  reg [7:0] clk_en_d;
  reg [7:0] acc_en_d;
  always @* begin
    clk_en_d = {8{run_io}} & ~pcs_eff;
    clk_en_d[`SPG_PCS_CONVERTER] = run_conv & ~pcs_eff[`SPG_PCS_CONVERTER];
    clk_en_d[`SPG_PCS_TIMER_B] = timer_b_async_select_i ? run_asy :
                                 (run_io & ~tb_sync_stop);
    clk_en_d[`SPG_PCS_RSVD] = 1'b0;
    acc_en_d = ~pcs_eff;
    acc_en_d[`SPG_PCS_TIMER_B] = ~tb_sync_stop;
    acc_en_d[`SPG_PCS_RSVD] = 1'b0;
  end

  wire deep = (state_q != ST_ACTIVE) & ~m_idle & ~m_noise;
  wire comp_on = comparator_enable_i & ~deep;

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      cpu_clk_en_o <= 1'b1;
      flash_clk_en_o <= 1'b1;
      io_clk_en_o <= 1'b1;
      converter_clk_en_o <= 1'b1;
      async_timer_clock_en_o <= 1'b1;
      main_osc_en_o <= 1'b1;
      timer_osc_en_o <= 1'b0;
      periph_clk_en_o <= 8'h00;
      periph_access_en_o <= 8'h00;
      comparator_en_o <= 1'b0;
      comparator_mux_allow_o <= 1'b0;
      converter_en_o <= 1'b0;
      converter_extended_o <= 1'b0;
      brownout_en_o <= 1'b0;
      vref_en_o <= 1'b0;
      watchdog_run_o <= 1'b0;
      input_buf_en_o <= 1'b1;
      analog_input_disable_o <= 16'h0000;
      sleeping_o <= 1'b0;
      conv_en_prev_q <= 1'b0;
      conv_ext_q <= 1'b1;
    end else begin
      cpu_clk_en_o <= run_cpu;
      flash_clk_en_o <= run_cpu;
      io_clk_en_o <= run_io;
      converter_clk_en_o <= run_conv;
      async_timer_clock_en_o <= run_asy;
      main_osc_en_o <= run_main;
      timer_osc_en_o <= run_tosc;
      periph_clk_en_o <= clk_en_d;
      periph_access_en_o <= acc_en_d;
      comparator_en_o <= comp_on;
      comparator_mux_allow_o <= ~pcs_eff[`SPG_PCS_CONVERTER];
      converter_en_o <= converter_enable_i;
      brownout_en_o <= brownout_level_fuse_i;
      vref_en_o <= brownout_level_fuse_i | comp_on |
                   converter_enable_i;
      watchdog_run_o <= watchdog_enable_i;
      input_buf_en_o <= run_io | run_conv;
      analog_input_disable_o <= {in_dis_hi_q, in_dis_lo_q};
      sleeping_o <= state_q != ST_ACTIVE;
      conv_en_prev_q <= converter_enable_i;
      // A fresh enable wins over a start seen in the same cycle.
      if (converter_enable_i & ~conv_en_prev_q) begin
        conv_ext_q <= 1'b1;
      end else if (converter_start_i) begin
        conv_ext_q <= 1'b0;
      end
      converter_extended_o <= conv_ext_q;
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------------
  wire do_write = aw_got_q & w_got_q & ~s_axi_bvalid_o;
  wire [2:0] widx = reg_index(awaddr_q);
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_awready_o <= 1'b1;
      s_axi_wready_o <= 1'b1;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= `SPG_RESP_OKAY;
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      awaddr_q <= {ADDR_W{1'b0}};
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      pcs_q <= `SPG_PCS_RESET;
      slp_ctrl_q <= `SPG_SLP_RESET;
      in_dis_lo_q <= `SPG_IN_DIS_RESET;
      in_dis_hi_q <= `SPG_IN_DIS_RESET;
      sense_q <= `SPG_SENSE_RESET;
    end else begin
      if (s_axi_awvalid_i & s_axi_awready_o) begin
        awaddr_q <= s_axi_awaddr_i;
        aw_got_q <= 1'b1;
        s_axi_awready_o <= 1'b0;
      end
      if (s_axi_wvalid_i & s_axi_wready_o) begin
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
        w_got_q <= 1'b1;
        s_axi_wready_o <= 1'b0;
      end
      if (do_write) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= (widx == `SPG_IDX_NONE) ? `SPG_RESP_SLVERR :
                         `SPG_RESP_OKAY;
        if (wstrb_q[0]) begin
          case (widx)
            `SPG_IDX_PCS: pcs_q <= wdata_q[7:0] & `SPG_PCS_WMASK;
            `SPG_IDX_SLEEP_CTRL: slp_ctrl_q <= wdata_q[3:0];
            `SPG_IDX_IN_DIS_LO: in_dis_lo_q <= wdata_q[7:0];
            `SPG_IDX_IN_DIS_HI: in_dis_hi_q <= wdata_q[7:0];
            `SPG_IDX_IRQ_SENSE: sense_q <= wdata_q[1:0];
            default: begin
            end
          endcase
        end
      end
      if (s_axi_bvalid_o & s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
        s_axi_awready_o <= 1'b1;
        s_axi_wready_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b1;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= `SPG_RESP_OKAY;
    end else begin
      if (s_axi_arvalid_i & s_axi_arready_o) begin
        s_axi_arready_o <= 1'b0;
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= `SPG_RESP_OKAY;
        case (reg_index(s_axi_araddr_i))
          `SPG_IDX_PCS: s_axi_rdata_o <= {24'h00_0000, pcs_eff};
          `SPG_IDX_SLEEP_CTRL: s_axi_rdata_o <= {28'h000_0000, slp_ctrl_q};
          `SPG_IDX_IN_DIS_LO: s_axi_rdata_o <= {24'h00_0000, in_dis_lo_q};
          `SPG_IDX_IN_DIS_HI: s_axi_rdata_o <= {24'h00_0000, in_dis_hi_q};
          `SPG_IDX_IRQ_SENSE: s_axi_rdata_o <= {30'h0000_0000, sense_q};
          `SPG_IDX_STATUS: s_axi_rdata_o <= {26'h000_0000, conv_ext_q,
                                             mode_q, state_q};
          default: begin
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= `SPG_RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_rvalid_o & s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
        s_axi_arready_o <= 1'b1;
      end
    end
  end

endmodule // spg_sleep_clock_ctrl

`default_nettype wire

// >>> spg_sleep_regs.vh
/*
 * Register map, field positions, mode codes and timing counts of the
 * sleep and peripheral clock gating block.
 * Assumes it is included once per compilation unit by its bare name.
 */
`ifndef SPG_SLEEP_REGS_VH
`define SPG_SLEEP_REGS_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define SPG_ADDR_PCS 8'h00
`define SPG_ADDR_SLEEP_CTRL 8'h04
`define SPG_ADDR_IN_DIS_LO 8'h08
`define SPG_ADDR_IN_DIS_HI 8'h0C
`define SPG_ADDR_IRQ_SENSE 8'h10
`define SPG_ADDR_STATUS 8'h14

// ----------------------------------------------------------------------
// Register indices returned by the address decoder
// ----------------------------------------------------------------------
`define SPG_IDX_PCS 3'h0
`define SPG_IDX_SLEEP_CTRL 3'h1
`define SPG_IDX_IN_DIS_LO 3'h2
`define SPG_IDX_IN_DIS_HI 3'h3
`define SPG_IDX_IRQ_SENSE 3'h4
`define SPG_IDX_STATUS 3'h5
`define SPG_IDX_NONE 3'h7

// ----------------------------------------------------------------------
// Peripheral clock shutdown fields
// ----------------------------------------------------------------------
`define SPG_PCS_TWO_WIRE 7
`define SPG_PCS_TIMER_B 6
`define SPG_PCS_TIMER_A 5
`define SPG_PCS_RSVD 4
`define SPG_PCS_TIMER_WIDE 3
`define SPG_PCS_SERIAL 2
`define SPG_PCS_UART 1
`define SPG_PCS_CONVERTER 0
`define SPG_PCS_WMASK 8'hEF
`define SPG_PCS_RESET 8'h00

// ----------------------------------------------------------------------
// Sleep control, sense and input disable fields
// ----------------------------------------------------------------------
`define SPG_SLP_EN_BIT 0
`define SPG_SLP_MODE_LSB 1
`define SPG_SLP_MODE_MSB 3
`define SPG_SLP_RESET 4'h0
`define SPG_SENSE_A_BIT 0
`define SPG_SENSE_B_BIT 1
`define SPG_SENSE_RESET 2'h0
`define SPG_IN_DIS_RESET 8'h00

// ----------------------------------------------------------------------
// Sleep mode codes and wake-up timing
// ----------------------------------------------------------------------
`define SPG_MODE_IDLE 3'h0
`define SPG_MODE_NOISE_RED 3'h1
`define SPG_MODE_POWER_DOWN 3'h2
`define SPG_MODE_POWER_SAVE 3'h3
`define SPG_MODE_STANDBY 3'h6
`define SPG_STANDBY_WAKE_CYC 16'h0006
`define SPG_QUICK_WAKE_CYC 16'h0001

// ----------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------
`define SPG_RESP_OKAY 2'h0
`define SPG_RESP_SLVERR 2'h2

`endif

// >>> spg_sleep_clock_ctrl_props.sv
/* Assertions on the sleep and clock gating block, bound to its top.
   Assumes one clock and a synchronous active-high reset. */
`default_nettype none
module spg_sleep_clock_ctrl_props (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic brownout_level_fuse_i,
  input wire logic debug_wire_fuse_i,
  input wire logic watchdog_enable_i,
  input wire logic converter_enable_i,
  input wire logic cpu_clk_en_o,
  input wire logic io_clk_en_o,
  input wire logic converter_clk_en_o,
  input wire logic main_osc_en_o,
  input wire logic [7:0] periph_clk_en_o,
  input wire logic [7:0] periph_access_en_o,
  input wire logic comparator_en_o,
  input wire logic brownout_en_o,
  input wire logic vref_en_o,
  input wire logic watchdog_run_o,
  input wire logic input_buf_en_o,
  input wire logic sleeping_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  // ------
  // Checks
  // ------
  AST_RSVD_ZERO: assert property (!periph_clk_en_o[4] && !periph_access_en_o[4])
    else $error("reserved bit active");
  AST_BOD_KEPT: assert property (brownout_level_fuse_i [*2] |-> brownout_en_o)
    else $error("brown-out off");
  AST_WDT_KEPT: assert property (watchdog_enable_i [*2] |-> watchdog_run_o)
    else $error("watchdog stopped");
  AST_DBG_OSC: assert property (debug_wire_fuse_i [*2] |-> main_osc_en_o)
    else $error("main oscillator off");
  AST_VREF_OFF: assert property ((!brownout_level_fuse_i && !converter_enable_i
    && !comparator_en_o) [*2] |-> !vref_en_o) else $error("reference on");
  AST_VREF_ON: assert property (converter_enable_i [*2] |-> vref_en_o)
    else $error("reference off");
  AST_IBUF_OFF: assert property ((!io_clk_en_o && !converter_clk_en_o) [*2]
    |-> !input_buf_en_o) else $error("input buffers on");
  AST_WAKE_CPU: assert property ($fell(sleeping_o) |-> ##[0:1] cpu_clk_en_o)
    else $error("cpu clock late");
  AST_SLEEP_CPU: assert property (sleeping_o [*3] |-> !cpu_clk_en_o)
    else $error("cpu clock in sleep");
  AST_ACCESS: assert property (!sleeping_o [*3] |-> periph_clk_en_o[7] ==
    periph_access_en_o[7] && periph_clk_en_o[5:0] == periph_access_en_o[5:0])
    else $error("access and clock differ");
endmodule // spg_sleep_clock_ctrl_props
`default_nettype wire

// >>> sleep_and_peripheral_clock_gating_tb.sv
/* Self-checking bench for the sleep and clock gating block.
   Assumes the design and its register header are compiled first. */
`default_nettype none
module sleep_and_peripheral_clock_gating_tb;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [15:0] OSC = 16'h0002;
  logic sys_clk_i, rst_i, sleep_req_i, nvm_ready_irq_i;
  logic converter_done_irq_i, other_io_irq_i, ext_irq_line_b_i;
  logic timer_b_async_select_i, converter_enable_i, converter_start_i;
  logic comparator_enable_i, brownout_level_fuse_i, debug_wire_fuse_i;
  logic watchdog_enable_i, s_axi_awvalid_i, s_axi_wvalid_i;
  logic s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
  logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
  logic [31:0] s_axi_wdata_i, s_axi_rdata_o, d;
  logic [3:0] s_axi_wstrb_i;
  logic [4:0] ev;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic s_axi_rvalid_o, cpu_clk_en_o, flash_clk_en_o, io_clk_en_o;
  logic converter_clk_en_o, async_timer_clock_en_o, main_osc_en_o;
  logic timer_osc_en_o, comparator_en_o, comparator_mux_allow_o;
  logic converter_en_o, converter_extended_o, brownout_en_o, vref_en_o;
  logic watchdog_run_o, input_buf_en_o, sleeping_o;
  logic [7:0] periph_clk_en_o, periph_access_en_o;
  logic [15:0] analog_input_disable_o;
  int n_errors, compares, n, n0, n2, n6;
  wire ext_irq_line_a_i = !ev[3];
  wire two_wire_match_i = ev[2];
  wire timer_b_irq_i = ev[1];
  wire watchdog_irq_i = ev[0];
  wire pin_change_i = ev[4];

  spg_sleep_clock_ctrl #(.OSC_START_CYC(OSC)) i_dut (.*);

  initial begin
    sys_clk_i = 0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  // ----------
  // Check and bus tasks
  // ----------
  task automatic chk(input logic [31:0] g, e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [3:0] s = 4'hF);
    @(posedge sys_clk_i);
    {s_axi_awaddr_i, s_axi_wdata_i, s_axi_wstrb_i} <= {a, v, s};
    {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'b111;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_awready_o) s_axi_awvalid_i <= 0;
      if (s_axi_wready_o) s_axi_wvalid_i <= 0;
    end while (s_axi_bvalid_o !== 1);
    r = s_axi_bresp_o;
    s_axi_bready_i <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge sys_clk_i);
    s_axi_araddr_i <= a;
    {s_axi_arvalid_i, s_axi_rready_i} <= 2'b11;
    do begin
      @(posedge sys_clk_i);
      if (s_axi_arready_o) s_axi_arvalid_i <= 0;
    end while (s_axi_rvalid_o !== 1);
    {d, r} = {s_axi_rdata_o, s_axi_rresp_o};
    s_axi_rready_i <= 0;
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_regs;
    rd(8'h00);
    chk(d, 0);
    wr(8'h00, 32'h0000_00FF);
    rd(8'h00);
    chk(d, 32'h0000_00EF);
    chk(periph_access_en_o, 0);
    wr(8'h00, 32'h0000_0000, 4'h0);
    chk(r, 0);
    chk(periph_access_en_o, 0);
    rd(8'h1C);
    chk(d, 0);
    chk(r, 2);
    wr(8'h1C, 32'h0000_0000);
    chk(r, 2);
    for (int i = 0; i < 8; i++) begin
      wr(8'h00, 32'(1 << i));
      repeat (3) @(posedge sys_clk_i);
      chk(periph_clk_en_o, ~(8'h01 << i) & 8'hEF);
      chk(periph_access_en_o, ~(8'h01 << i) & 8'hEF);
    end
    timer_b_async_select_i <= 1;
    wr(8'h00, 32'h0000_0040);
    repeat (3) @(posedge sys_clk_i);
    chk(periph_clk_en_o, 8'hEF);
    chk(periph_access_en_o, 8'hEF);
    timer_b_async_select_i <= 0;
    wr(8'h00, 32'h0000_0000);
    wr(8'h08, 32'h0000_00A5);
    wr(8'h0C, 32'h0000_005A);
    repeat (3) @(posedge sys_clk_i);
    chk(analog_input_disable_o, 16'h5AA5);
  endtask
  // Sleeps in mode m, offers the refused sources b, then wakes on g.
  task automatic slp(input logic [2:0] m, input logic [12:0] e,
                     input logic [4:0] b, g, output int k);
    wr(8'h04, 32'({m, 1'b1}));
    sleep_req_i <= 1;
    @(posedge sys_clk_i) sleep_req_i <= 0;
    repeat (4) @(posedge sys_clk_i);
    chk({cpu_clk_en_o, flash_clk_en_o, io_clk_en_o, converter_clk_en_o,
      async_timer_clock_en_o, main_osc_en_o, timer_osc_en_o,
      comparator_en_o, input_buf_en_o, brownout_en_o, watchdog_run_o,
      vref_en_o, converter_en_o}, e);
    ev <= b;
    repeat (8) @(posedge sys_clk_i);
    ev <= 0;
    @(posedge sys_clk_i);
    chk(sleeping_o, 1);
    ev <= g;
    k = 0;
    do begin
      @(posedge sys_clk_i);
      k++;
    end while (cpu_clk_en_o !== 1 && k < 99);
    ev <= 0;
    chk(cpu_clk_en_o, 1);
  endtask
  task automatic t_conv;
    converter_start_i <= 1;
    @(posedge sys_clk_i) converter_start_i <= 0;
    repeat (3) @(posedge sys_clk_i);
    chk(converter_extended_o, 0);
    converter_enable_i <= 0;
    wr(8'h00, 32'h0000_0001);
    repeat (3) @(posedge sys_clk_i);
    chk(comparator_mux_allow_o, 0);
    wr(8'h00, 32'h0000_0000);
    converter_enable_i <= 1;
    repeat (3) @(posedge sys_clk_i);
    chk({comparator_mux_allow_o, converter_extended_o}, 3);
  endtask

  initial begin
    {sleep_req_i, nvm_ready_irq_i, converter_done_irq_i,
     other_io_irq_i, timer_b_async_select_i, converter_enable_i,
     converter_start_i, brownout_level_fuse_i, debug_wire_fuse_i,
     watchdog_enable_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i,
     s_axi_arvalid_i, s_axi_rready_i, ev} = '0;
    {rst_i, ext_irq_line_b_i, comparator_enable_i} = '1;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, s_axi_wstrb_i} = '0;
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 0;
    t_regs;
    slp(3'h0, 13'h7B2, 4'h0, 4'h1, n0);
    slp(3'h1, 13'h3B2, 4'h8, 4'h1, n);
    slp(3'h2, 13'h000, 4'hA, 4'h1, n2);
    slp(3'h3, 13'h140, 4'h8, 4'h1, n);
    slp(3'h6, 13'h080, 4'hA, 4'h1, n6);
    chk(n6 - n0, 5);
    chk(n2 - n0, OSC - 1);
    timer_b_async_select_i <= 1;
    slp(3'h0, 13'h7F2, 4'h0, 4'h1, n);
    {timer_b_async_select_i, debug_wire_fuse_i, brownout_level_fuse_i,
     watchdog_enable_i, converter_enable_i} <= 5'b01111;
    slp(3'h2, 13'h08F, 4'hA, 4'h1, n);
    {debug_wire_fuse_i, brownout_level_fuse_i, watchdog_enable_i} <= '0;
    wr(8'h10, 32'h0000_0001);
    slp(3'h2, 13'h003, 4'h2, 4'h8, n);
    slp(3'h2, 13'h003, 5'h02, 5'h10, n);
    t_conv;
    finish_test;
  end
  initial begin
    repeat (5000) @(posedge sys_clk_i);
    n_errors++;
    finish_test;
  end
  task automatic finish_test;
    if (n_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
endmodule // sleep_and_peripheral_clock_gating_tb
bind spg_sleep_clock_ctrl spg_sleep_clock_ctrl_props i_props (.*);
`default_nettype wire
